// ### dv/line_receiver.sv
// Behavioural far-end receiver that decodes and polices frames on the line
`timescale 1ns/10ps
`default_nettype none
module line_receiver (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Line and shared frame format
   input  wire logic       line,
   input  wire logic [7:0] divisor,
   input  wire logic       nine,
   input  wire logic       two_stop,
   // Decoded character
   output logic            rx_done,
   output logic [8:0]      rx_data,
   output logic            rx_bad
);
   int   nb;    // Data bits in this frame
   int   nbits; // Whole frame length in bits
   logic v;     // Level taken at the first clock of a bit
   // Samples every clock, so a glitch inside a bit is caught, not voted away
   initial begin
      rx_done = 1'b0;
      rx_data = 9'h000;
      rx_bad  = 1'b0;
      forever begin
         @(posedge clock);
         rx_done <= 1'b0;
         // Wait for a space on an idle line
         if (reset || line !== 1'b0) continue;
         nb = nine ? 9 : 8;
         nbits = 1 + nb + (two_stop ? 2 : 1);
         v = 1'b0;
         for (int i = 0; i < nbits; i++) begin
            if (i > 0) begin
               @(posedge clock);
               v = line;
            end
            // Whole bit at one level, no return to neutral
            for (int c = 0; c < divisor; c++) begin
               @(posedge clock);
               if (line !== v) rx_bad <= 1'b1;
            end
            if (i >= 1 && i <= nb) rx_data[i-1] <= v;
            if (i > nb && v !== 1'b1) rx_bad <= 1'b1;
         end
         if (nb == 8) rx_data[8] <= 1'b0;
         rx_done <= 1'b1;
      end
   end
endmodule // line_receiver
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the asynchronous serial transmitter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // Stimulus
   logic       clock = 1'b0;
   logic       reset = 1'b1;
   logic       tx_en = 1'b0, mode = 1'b0, spe = 1'b0, nine = 1'b0, two_stop = 1'b0;
   logic       irq_en = 1'b0, si = 1'b0, dir = 1'b0, latch = 1'b0;
   logic [7:0] div = 8'h01;
   logic       wr_valid = 1'b0;
   logic [8:0] wr_data = 9'h000;
   logic [2:0] si_h = 3'h0;  // Input pin history, newest in bit 0
   logic [1:0] lt_h = 2'h0;  // Port latch history
   logic [31:0] r;           // Random word of the cycle
   // Observed
   wire logic  wr_ready, flag, irq, busy, so, so_oe, si_o, si_oe, si_val, rx_done, rx_bad;
   wire logic [8:0] rx_data;
   // Bookkeeping
   int         err_total = 0, checked = 0, cyc = 0, rx_cnt = 0, t_first = -1, t_last = 0;
   int         seed = 32'h86b0;
   logic [8:0] exp_q[$];     // Characters still expected on the line
   logic       saw_full = 1'b0;

   async_serial_transmitter #(.FIFO_DEPTH(4)) u_dut (.clock(clock), .reset(reset),
      .tx_enable_bit(tx_en), .clocked_mode_sel(mode), .serial_port_enable(spe),
      .ninth_bit_enable(nine), .two_stop_bits(two_stop), .baud_divisor(div),
      .tx_irq_enable(irq_en), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .tx_buffer_empty_flag(flag), .tx_irq_req(irq), .tx_shift_busy(busy),
      .serial_out_o(so), .serial_out_oe(so_oe), .serial_in_i(si), .serial_in_o(si_o),
      .serial_in_oe(si_oe), .pin_direction_bit(dir), .port_latch_data(latch),
      .serial_in_value(si_val));
   line_receiver u_rx (.clock(clock), .reset(reset), .line(so), .divisor(div), .nine(nine),
      .two_stop(two_stop), .rx_done(rx_done), .rx_data(rx_data), .rx_bad(rx_bad));

   always #4 clock = ~clock;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hold the write until taken; note any refusal
   task automatic put_char(input logic [8:0] d);
      wr_valid <= 1'b1;
      wr_data <= d;
      exp_q.push_back(nine ? d : {1'b0, d[7:0]});
      @(negedge clock);
      while (wr_ready !== 1'b1) begin
         saw_full = 1'b1;
         @(negedge clock);
      end
      @(posedge clock);
   endtask

   // Back-to-back characters in one format; frames must chain with no gap
   task automatic burst(input int k, input int d, input logic n9, input logic s2);
      int n;
      int base;
      n = 1 + (n9 ? 9 : 8) + (s2 ? 2 : 1);
      @(posedge clock);
      div <= 8'(d);
      nine <= n9;
      two_stop <= s2;
      t_first = -1;
      saw_full = 1'b0;
      base = rx_cnt;
      @(posedge clock);
      for (int i = 0; i < k; i++) put_char(9'($random(seed)));
      wr_valid <= 1'b0;
      if (k > 1) begin
         repeat (2) @(posedge clock);
         @(negedge clock);
         chk(flag, 1'b0);
      end
      while (rx_cnt < base + k) @(negedge clock);
      chk(t_last - t_first, k * n * (d + 1));
      @(negedge clock);
      chk(flag, 1'b1);
      if (k == 7 && d >= 10) chk(saw_full, 1'b1);
   endtask

   // Random pin traffic, cycle count and hang limit
   always @(posedge clock) begin
      r = $random(seed);
      si <= r[0];
      dir <= r[1];
      latch <= r[2];
      irq_en <= r[3] && wr_valid;
      si_h <= {si_h[1:0], r[0]};
      lt_h <= {lt_h[0], r[2]};
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         test_done();
      end
   end

   // Checks that hold on every cycle, plus the receive scoreboard
   always @(negedge clock) begin
      if (!reset && cyc > 15) begin
         chk(so_oe, spe);
         chk(si_oe, !spe && !dir);
         chk(si_val, si_h[2]);
         chk(si_o, lt_h[1]);
         chk(irq, flag && irq_en);
         if (!busy) chk(so, 1'b1);
         if (so === 1'b0 && t_first < 0) t_first = cyc;
         if (rx_done) begin
            rx_cnt++;
            t_last = cyc;
            chk(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff);
         end
      end
   end

   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      chk({so, flag, busy, wr_ready}, 4'h9);
      @(posedge clock);
      tx_en <= 1'b1;
      spe <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk(flag, 1'b1);
      // Transmit enable off, clocked mode, port enable off in turn: writes wait, line stays at mark
      for (int j = 0; j < 3; j++) begin
         @(posedge clock);
         tx_en <= (j != 0);
         mode <= (j == 1);
         spe <= (j != 2);
         @(posedge clock);
         put_char(9'h0a5 ^ 9'(j));
         wr_valid <= 1'b0;
         repeat (40) begin
            @(negedge clock);
            chk({so, busy, flag}, 3'h4);
         end
         @(posedge clock);
         tx_en <= 1'b1;
         mode <= 1'b0;
         spe <= 1'b1;
         while (rx_cnt < j + 1) @(negedge clock);
      end
      // Corners: FIFO fills and refuses, slowest bit, fastest bit
      burst(7, 40, 1'b0, 1'b0);
      burst(1, 255, 1'b1, 1'b1);
      burst(3, 0, 1'b1, 1'b0);
      repeat (16) burst(1 + $unsigned($random(seed)) % 7, $unsigned($random(seed)) % 8,
                        1'($random(seed)), 1'($random(seed)));
      chk(rx_bad, 1'b0);
      chk(exp_q.size(), 0);
      test_done();
   end
endmodule // tb_top
`default_nettype wire

// ### verilog/async_serial_transmitter.sv
// Asynchronous serial transmitter with input FIFO and pin control
`timescale 1ns/10ps
`default_nettype none
`include "tx_consts.svh"

// Small synchronous FIFO, valid/ready on both sides
module char_fifo #(
   parameter int WIDTH = `CHAR_WIDTH,
   parameter int DEPTH = `TX_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   // Power of two keeps pointer wrap free
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("char_fifo depth must be a power of two");
      end
   endgenerate

   // FIFO state in one struct
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } fifo_state_t;

   fifo_state_t s_r;                 // Registered state
   fifo_state_t s_nxt;               // Next state
   logic        push;                // Word accepted
   logic        pop;                 // Word handed out

   // Honest full and empty from the count
   assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp          = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      // Simultaneous push and pop keeps the count
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // char_fifo

// Transmitter top
module async_serial_transmitter
   import tx_pkg::*;
#(
   parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Control bits
   input  wire logic       tx_enable_bit,
   input  wire logic       clocked_mode_sel,
   input  wire logic       serial_port_enable,
   input  wire logic       ninth_bit_enable,
   input  wire logic       two_stop_bits,
   input  wire logic [7:0] baud_divisor,
   input  wire logic       tx_irq_enable,
   // Character write port
   input  wire logic       wr_valid,
   output logic            wr_ready,
   input  wire logic [8:0] wr_data,
   // Status
   output logic            tx_buffer_empty_flag,
   output logic            tx_irq_req,
   output logic            tx_shift_busy,
   // Serial output pin
   output logic            serial_out_o,
   output logic            serial_out_oe,
   // Serial input pin and its port logic
   input  wire logic       serial_in_i,
   output logic            serial_in_o,
   output logic            serial_in_oe,
   input  wire logic       pin_direction_bit,
   input  wire logic       port_latch_data,
   output logic            serial_in_value
);
   generate
      if (FIFO_DEPTH < 2) begin : g_bad_param
         $error("FIFO_DEPTH below two is not served");
      end
   endgenerate

   tx_state_t  s_r;                  // Registered state
   tx_state_t  s_nxt;                // Next state
   logic       active;               // Async transmit selected
   logic       tick;                 // End of a bit period
   logic       load;                 // Buffer moves into shifter
   logic       frame_end;            // Last stop bit ends now
   logic [3:0] last_bit;             // Index of final data bit
   logic       fifo_valid;           // Character waiting in FIFO
   logic       fifo_take;            // Buffer takes from FIFO
   logic [8:0] fifo_data;            // FIFO head

   // Only async mode with both enables transmits
   assign active   = tx_enable_bit && !clocked_mode_sel && serial_port_enable;
   // Ninth bit is plain data; parity is software's job
   // Format ports are shared with the receive side, never copied here
   assign last_bit = ninth_bit_enable ? `LAST_BIT_NINE : `LAST_BIT_EIGHT;
   // Divider reaching zero closes a bit
   assign tick     = (s_r.baud_cnt == `BAUD_RESET);
   assign frame_end = (s_r.state == ST_STOP) && tick &&
                      (s_r.stop_cnt == two_stop_bits);
   // Shifter only ever fills from the buffer register
   assign load = active && s_r.buf_full &&
                 ((s_r.state == ST_IDLE) || frame_end);
   // Buffer refills from FIFO once free, stalling FIFO otherwise
   assign fifo_take = active && fifo_valid && (!s_r.buf_full || load);

   // Write FIFO ahead of the buffer register
   char_fifo #(
      .WIDTH (`CHAR_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .reset     (reset),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_take),
      .out_data  (fifo_data)
   );

   // Next-state logic for frame, buffer, flag and pins
   always_comb begin
      s_nxt = s_r;
      // Divider counts down, reloads each period
      s_nxt.baud_cnt = tick ? baud_divisor : s_r.baud_cnt - 1'b1;
      case (s_r.state)
         ST_IDLE: begin
            s_nxt.baud_cnt = baud_divisor;
         end
         ST_START: begin
            if (tick) begin
               s_nxt.state   = ST_DATA;
               s_nxt.bit_cnt = `CNT_RESET;
            end
         end
         ST_DATA: begin
            if (tick) begin
               // Shift right so bit zero leaves first
               s_nxt.transmit_shift_register     = {1'b0, s_r.transmit_shift_register[8:1]};
               s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
               if (s_r.bit_cnt == last_bit) begin
                  s_nxt.state    = ST_STOP;
                  s_nxt.stop_cnt = 1'b0;
               end
            end
         end
         ST_STOP: begin
            if (tick) begin
               s_nxt.stop_cnt = 1'b1;
               if (frame_end) begin
                  s_nxt.state = ST_IDLE;
               end
            end
         end
         default: begin
            s_nxt.state = ST_IDLE;
         end
      endcase
      // Buffer to shifter transfer restarts the bit clock
      if (load) begin
         s_nxt.transmit_shift_register      = s_r.buf_data;
         s_nxt.state    = ST_START;
         s_nxt.baud_cnt = baud_divisor;
         s_nxt.buf_full = 1'b0;
      end
      if (fifo_take) begin
         s_nxt.buf_data = fifo_data;
         s_nxt.buf_full = 1'b1;
      end
      // Disabling drops frame and buffered character; FIFO keeps its characters
      if (!active) begin
         s_nxt.state    = ST_IDLE;
         s_nxt.buf_full = 1'b0;
      end
      // Line level from next state; NRZ holds between edges
      case (s_nxt.state)
         ST_START: s_nxt.line = `LINE_SPACE;
         ST_DATA:  s_nxt.line = s_nxt.transmit_shift_register[0];
         default:  s_nxt.line = `LINE_MARK;
      endcase
      // Hardware-only flag; no software write path exists
      s_nxt.flag = active && !s_nxt.buf_full && !fifo_valid;
      // Two-stage synchroniser on the input pin
      s_nxt.sync1     = serial_in_i;
      s_nxt.sync2     = s_r.sync1;
      s_nxt.latch_out = port_latch_data;
   end

   // State register, synchronous reset
   always_ff @(posedge clock) begin
      if (reset) begin
         s_r          <= '0;
         s_r.state    <= ST_IDLE;
         s_r.line     <= `LINE_MARK;
         s_r.transmit_shift_register      <= `CHAR_RESET;
         s_r.buf_data <= `CHAR_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Flag registered, so it settles two cycles after a write
   assign tx_buffer_empty_flag = s_r.flag;
   // Enable gates only the request
   assign tx_irq_req           = s_r.flag && tx_irq_enable;
   assign tx_shift_busy        = (s_r.state != ST_IDLE);
   // Output pin driven while the port is on
   assign serial_out_o         = s_r.line;
   assign serial_out_oe        = serial_port_enable;
   // Port on forces input pin, latch data blocked
   assign serial_in_oe         = !serial_port_enable && !pin_direction_bit;
   assign serial_in_o          = s_r.latch_out;
   assign serial_in_value      = s_r.sync2;

   // Checks on the frame and pin behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence seq_idle_write;
      active && s_r.state == ST_IDLE && !s_r.buf_full && !fifo_valid && wr_valid && wr_ready;
   endsequence
   sequence seq_start_seen;
      ##[1:3] (s_r.state == ST_START && s_r.line == `LINE_SPACE);
   endsequence

   a_idle_line_mark: assert property (
      s_r.state == ST_IDLE |-> serial_out_o == `LINE_MARK)
      else $error("line not mark while idle");
   a_start_is_space: assert property (
      s_r.state == ST_START |-> serial_out_o == `LINE_SPACE)
      else $error("start bit not space");
   a_stop_is_mark: assert property (
      s_r.state == ST_STOP |-> serial_out_o == `LINE_MARK)
      else $error("stop bit not mark");
   a_data_lsb_first: assert property (
      s_r.state == ST_DATA && $past(s_r.state == ST_DATA && tick) |->
      serial_out_o == $past(s_r.transmit_shift_register[1]))
      else $error("data bit order wrong");
   a_bit_hold_time: assert property (
      $changed(s_r.line) |-> $past(tick || load || !active))
      else $error("line moved inside a bit period");
   a_frame_bits: assert property (
      s_r.state == ST_STOP && $past(s_r.state) == ST_DATA |->
      $past(s_r.bit_cnt) == $past(last_bit))
      else $error("wrong data bit count");
   a_inactive_idle: assert property (
      !active |=> s_r.state == ST_IDLE && !tx_buffer_empty_flag)
      else $error("transmitter runs while disabled");
   a_pin_dirs: assert property (
      serial_port_enable |-> serial_out_oe && !serial_in_oe)
      else $error("pin directions wrong with port on");
   a_enable_flag: assert property (
      $rose(active) |=> tx_buffer_empty_flag || fifo_valid || s_r.buf_full)
      else $error("flag not set on enable");
   a_idle_load: assert property (
      seq_idle_write |-> seq_start_seen)
      else $error("idle write did not start a frame");
   a_queue_after_stop: assert property (
      active && frame_end && s_r.buf_full |=> s_r.state == ST_START)
      else $error("queued character not loaded after stop");
   a_flag_clear_cause: assert property (
      active && $fell(tx_buffer_empty_flag) |-> $past(s_nxt.buf_full || fifo_valid))
      else $error("flag cleared without a queued character");
   a_irq_gate: assert property (
      tx_irq_req |-> tx_buffer_empty_flag && tx_irq_enable)
      else $error("request without flag and enable");

   // Steps of a load and of an empty transmitter, for the checks below
   sequence seq_load_now;
      load;
   endsequence
   sequence seq_frame_begins;
      ##1 (tx_shift_busy && serial_out_o == `LINE_SPACE);
   endsequence
   sequence seq_quiet_empty;
      active && !s_r.buf_full && !fifo_valid;
   endsequence
   sequence seq_flag_up;
      ##1 tx_buffer_empty_flag;
   endsequence

   // Shifter takes exactly the buffered word
   a_load_from_buf: assert property (
      load |=> s_r.transmit_shift_register == $past(s_r.buf_data))
      else $error("shifter loaded from wrong source");

   // A load puts the start bit on the line at the next edge
   // No idle gap, so chained frames stay back to back
   a_load_starts: assert property (
      seq_load_now |-> seq_frame_begins)
      else $error("load did not begin a frame");

   // Start to data does not shift, so bit zero is first
   a_first_data_bit: assert property (
      s_r.state == ST_DATA && $past(s_r.state) == ST_START |->
      serial_out_o == $past(s_r.transmit_shift_register[0]))
      else $error("first data bit is not bit zero");

   // A second stop bit only when two were asked for
   a_second_stop: assert property (
      s_r.state == ST_STOP && $past(s_r.state == ST_STOP && tick) |-> two_stop_bits)
      else $error("extra stop bit sent");

   // Nothing queued and nothing written keeps the flag up
   a_flag_when_empty: assert property (
      seq_quiet_empty ##0 !wr_valid |-> seq_flag_up)
      else $error("flag low with nothing queued");

   // A write onto an empty path must not drop the flag at once
   // Software polling one cycle early must not see a stale clear
   a_flag_not_early: assert property (
      active && tx_buffer_empty_flag && !fifo_valid && wr_valid && wr_ready |=>
      tx_buffer_empty_flag)
      else $error("flag cleared right after a write");

   // Any enable off returns the line to mark
   a_disable_mark: assert property (
      !active |=> serial_out_o == `LINE_MARK)
      else $error("line not mark while disabled");

   // Pin value reaches software through two flip-flops
   a_sync_two_flops: assert property (
      !$past(reset, 2) && !$past(reset) |-> serial_in_value == $past(serial_in_i, 2))
      else $error("input pin not synchronised");

   // Port latch copy is kept, only its driver is blocked
   a_latch_path: assert property (
      !$past(reset) |-> serial_in_o == $past(port_latch_data))
      else $error("latch copy wrong");

   // Flag and enable together always raise the request
   a_irq_follow: assert property (
      tx_buffer_empty_flag && tx_irq_enable |-> tx_irq_req)
      else $error("request missing with flag and enable");
endmodule // async_serial_transmitter
`default_nettype wire

// ### verilog/tx_consts.svh
// Constants for the asynchronous serial transmitter
`ifndef TX_CONSTS_SVH
`define TX_CONSTS_SVH
`define LINE_MARK        1'b1
`define LINE_SPACE       1'b0
`define LAST_BIT_EIGHT   4'h7
`define LAST_BIT_NINE    4'h8
`define BAUD_WIDTH       8
`define CHAR_WIDTH       9
`define TX_FIFO_DEPTH    4
`define BAUD_RESET       8'h00
`define CHAR_RESET       9'h000
`define CNT_RESET        4'h0
`endif

// ### verilog/tx_pkg.sv
// Types shared by the asynchronous serial transmitter
package tx_pkg;
   // Frame sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b10,
      ST_STOP  = 2'b11
   } frame_state_t;

   // Whole transmitter state
   typedef struct packed {
      frame_state_t state;
      logic [8:0]   transmit_shift_register;
      logic [3:0]   bit_cnt;
      logic         stop_cnt;
      logic [7:0]   baud_cnt;
      logic [8:0]   buf_data;
      logic         buf_full;
      logic         line;
      logic         flag;
      logic         sync1;
      logic         sync2;
      logic         latch_out;
   } tx_state_t;
endpackage
